// ===== core/zqcal_ctl.sv
// controller end: schedules long and short calibration with all preconditions except arbitration between ranks that see share_busy_in low in one cycle
module zqcal_ctl
  import zqcal_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  zqcal_if.ctl      link,
  input  wire logic zq_req_in,
  input  wire logic zq_long_in,
  input  wire logic sr_exit_in,
  input  wire logic share_busy_in,
  output logic      share_busy_out,
  output logic      ready_out,
  output logic      busy_out,
  output logic      done_out
);
  `include "zqcal_defines.svh"

  zqcal_state_t             st_q;
  logic [`ZQCAL_CNT_W-1:0]  cnt_q;
  logic [`ZQCAL_CNT_W-1:0]  txs_q;
  logic                     first_q;
  logic                     long_q;
  logic                     pend_q;
  logic                     pend_long_q;

  ////////////////////////////////////////////////////////////////////////////
  // request latch; held until the command is actually issued
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_q      <= 1'b0;
      pend_long_q <= 1'b0;
    end else if (zq_req_in && !pend_q && st_q == ZQCAL_ST_IDLE) begin
      pend_q      <= 1'b1;
      pend_long_q <= zq_long_in;
    end else if (st_q == ZQCAL_ST_WAIT && cnt_q == '0 && txs_q == '0 && !share_busy_in) begin
      pend_q      <= 1'b0;
    end
  end

  // tXS countdown after self-refresh exit; calibration may overlap dll lock
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      txs_q <= '0;
    end else if (sr_exit_in) begin
      txs_q <= `ZQCAL_CNT_W'(`ZQCAL_TXS_CYC);
    end else if (txs_q != '0) begin
      txs_q <= txs_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: precharge all, wait tRP (and tXS), issue, hold quiet window
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q    <= ZQCAL_ST_IDLE;
      cnt_q   <= '0;
      first_q <= 1'b1;
      long_q  <= 1'b0;
    end else begin
      case (st_q)
        ZQCAL_ST_IDLE: begin
          if (pend_q) begin
            st_q  <= ZQCAL_ST_WAIT;
            cnt_q <= `ZQCAL_CNT_W'(`ZQCAL_TRP_CYC);
          end
        end
        ZQCAL_ST_WAIT: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (txs_q == '0 && !share_busy_in) begin
            st_q   <= ZQCAL_ST_CAL;
            long_q <= pend_long_q;
            if (pend_long_q && first_q) begin
              cnt_q <= `ZQCAL_CNT_W'(`ZQCAL_TZQINIT_CYC - 1);
            end else if (pend_long_q) begin
              cnt_q <= `ZQCAL_CNT_W'(`ZQCAL_TZQOPER_CYC - 1);
            end else begin
              cnt_q <= `ZQCAL_CNT_W'(`ZQCAL_TZQCS_CYC - 1);
            end
            if (pend_long_q) begin
              first_q <= 1'b0;
            end
          end
        end
        ZQCAL_ST_CAL: begin
          if (cnt_q == '0) begin
            st_q <= ZQCAL_ST_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ZQCAL_ST_DONE: begin
          st_q <= ZQCAL_ST_IDLE;
        end
        default: begin
          st_q <= ZQCAL_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link outputs, registered
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.cmd  <= ZQCAL_CMD_NOP;
      link.addr <= '0;
    end else if (st_q == ZQCAL_ST_IDLE && pend_q) begin
      link.cmd  <= ZQCAL_CMD_PRE;
      link.addr <= `ZQCAL_ADDR_W'(1) << `ZQCAL_LONG_BIT; // precharge all uses the same bit
    end else if (st_q == ZQCAL_ST_WAIT && cnt_q == '0 && txs_q == '0 && !share_busy_in) begin
      link.cmd  <= ZQCAL_CMD_ZQ;
      link.addr <= `ZQCAL_ADDR_W'(pend_long_q) << `ZQCAL_LONG_BIT;
    end else begin
      link.cmd  <= ZQCAL_CMD_NOP;
      link.addr <= '0;
    end
  end

  // cke low in reset and high after it, odt/dq off; this end never drives data in this block
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.cke       <= 1'b0;
      link.odt       <= 1'b0;
      link.ctl_dq_oe <= 1'b0;
    end else begin
      link.cke       <= 1'b1;
      link.odt       <= 1'b0;
      link.ctl_dq_oe <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (st_q == ZQCAL_ST_CAL) && (cnt_q == '0);
    end
  end

  assign busy_out       = (st_q != ZQCAL_ST_IDLE) || pend_q;
  assign share_busy_out = (st_q == ZQCAL_ST_CAL);
  assign ready_out      = (st_q == ZQCAL_ST_IDLE) && !pend_q;

endmodule // zqcal_ctl

// ===== core/zqcal_defines.svh
// timing constants and command field positions for the calibration sequencer
// Function
// - long calibration used in power-up initialization
// - controller may issue long calibration later
// - long calibration runs engine, updates IO values
// - first long calibration after reset gets init window
// - later long calibrations get operating window
// - short calibration gets short window
// - no channel activity during calibration window
// - calibration current path off after completion
// - all banks precharged and tRP met first
// - calibration may overlap DLL lock after self refresh
// - no self-initiated recalibration on self refresh exit
// - no calibration earlier than tXS after exit
// - shared resistor windows never overlap between ranks; two ranks that see share_busy_in low in the same cycle both issue
// - clock enable held high during calibration
// - termination disabled during calibration
// - data bus high impedance during calibration
`ifndef ZQCAL_DEFINES_SVH
`define ZQCAL_DEFINES_SVH
`define ZQCAL_CLK_PERIOD_NS   10
`define ZQCAL_TZQINIT_NS      5120
`define ZQCAL_TZQOPER_NS      2560
`define ZQCAL_TZQCS_NS        640
`define ZQCAL_TRP_NS          15
`define ZQCAL_TXS_NS          270
`define ZQCAL_TZQINIT_CYC     ((`ZQCAL_TZQINIT_NS + `ZQCAL_CLK_PERIOD_NS - 1) / `ZQCAL_CLK_PERIOD_NS)
`define ZQCAL_TZQOPER_CYC     ((`ZQCAL_TZQOPER_NS + `ZQCAL_CLK_PERIOD_NS - 1) / `ZQCAL_CLK_PERIOD_NS)
`define ZQCAL_TZQCS_CYC       ((`ZQCAL_TZQCS_NS + `ZQCAL_CLK_PERIOD_NS - 1) / `ZQCAL_CLK_PERIOD_NS)
`define ZQCAL_TRP_CYC         ((`ZQCAL_TRP_NS + `ZQCAL_CLK_PERIOD_NS - 1) / `ZQCAL_CLK_PERIOD_NS)
`define ZQCAL_TXS_CYC         ((`ZQCAL_TXS_NS + `ZQCAL_CLK_PERIOD_NS - 1) / `ZQCAL_CLK_PERIOD_NS)
`define ZQCAL_CNT_W           10
`define ZQCAL_LONG_BIT        10
`define ZQCAL_ADDR_W          14
`define ZQCAL_DQ_W            16
`define ZQCAL_CAL_W           8
`define ZQCAL_CAL_RESET       8'h80
`endif

// ===== core/zqcal_dev.sv
// device end: decodes calibration commands, runs engine, updates io values
`include "zqcal_defines.svh"
module zqcal_dev
  import zqcal_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   rstn_in,
  zqcal_if.dev                        link,
  input  wire logic [`ZQCAL_CAL_W-1:0] cal_target_in,
  output logic [`ZQCAL_CAL_W-1:0]     drv_code_out,
  output logic [`ZQCAL_CAL_W-1:0]     odt_code_out,
  output logic                        cal_active_out,
  output logic                        cal_current_out,
  output logic                        viol_out
);
  logic [`ZQCAL_CNT_W-1:0]  cnt_q;
  logic [`ZQCAL_CAL_W-1:0]  eng_q;
  logic                     first_q;
  logic                     run_q;
  logic                     zq_cmd;

  // only an explicit command starts calibration; self refresh exit does not
  assign zq_cmd = link.cke && (link.cmd == ZQCAL_CMD_ZQ);

  ////////////////////////////////////////////////////////////////////////////
  // window timer; long window length depends on first-after-reset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q   <= '0;
      run_q   <= 1'b0;
      first_q <= 1'b1;
    end else if (zq_cmd && !run_q) begin
      run_q <= 1'b1;
      if (link.addr[`ZQCAL_LONG_BIT]) begin
        first_q <= 1'b0;
        cnt_q   <= first_q ? `ZQCAL_CNT_W'(`ZQCAL_TZQINIT_CYC - 1)
                           : `ZQCAL_CNT_W'(`ZQCAL_TZQOPER_CYC - 1);
      end else begin
        cnt_q <= `ZQCAL_CNT_W'(`ZQCAL_TZQCS_CYC - 1);
      end
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine steps one code per cycle toward target; result moves to io at end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eng_q        <= `ZQCAL_CAL_RESET;
      drv_code_out <= `ZQCAL_CAL_RESET;
      odt_code_out <= `ZQCAL_CAL_RESET;
    end else if (run_q) begin
      if (eng_q < cal_target_in) begin
        eng_q <= eng_q + 1'b1;
      end else if (eng_q > cal_target_in) begin
        eng_q <= eng_q - 1'b1;
      end
      if (cnt_q == '0) begin
        drv_code_out <= eng_q;
        odt_code_out <= eng_q;
      end
    end
  end

  // sticky flag: traffic, cke low, odt or driven dq inside a window
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      viol_out <= 1'b0;
    end else if (run_q && (link.cmd != ZQCAL_CMD_NOP || !link.cke || link.odt
                           || link.ctl_dq_oe)) begin
      viol_out <= 1'b1;
    end
  end

  assign cal_active_out  = run_q;
  assign cal_current_out = run_q;
  assign link.dev_dq_oe  = 1'b0;

endmodule // zqcal_dev

// ===== core/zqcal_if.sv
// command/address link between controller and memory device
interface zqcal_if;
  import zqcal_pkg::*;
  `include "zqcal_defines.svh"
  zqcal_cmd_t               cmd;
  logic [`ZQCAL_ADDR_W-1:0] addr;
  logic                     cke;
  logic                     odt;
  logic                     ctl_dq_oe;
  logic                     dev_dq_oe;
  modport ctl (output cmd, output addr, output cke, output odt, output ctl_dq_oe,
               input dev_dq_oe);
  modport dev (input cmd, input addr, input cke, input odt, input ctl_dq_oe,
               output dev_dq_oe);
endinterface : zqcal_if

// ===== core/zqcal_pkg.sv
// types shared by both ends of the calibration link
package zqcal_pkg;
  // command code carried on the {cs_n,ras_n,cas_n,we_n} lines
  typedef enum logic [3:0] {
    ZQCAL_CMD_NOP = 4'h7,
    ZQCAL_CMD_PRE = 4'h2,
    ZQCAL_CMD_SRX = 4'hF,
    ZQCAL_CMD_ZQ  = 4'h6,
    ZQCAL_CMD_DES = 4'h8
  } zqcal_cmd_t;
  typedef enum logic [1:0] {
    ZQCAL_ST_IDLE = 2'b00,
    ZQCAL_ST_WAIT = 2'b01,
    ZQCAL_ST_CAL  = 2'b11,
    ZQCAL_ST_DONE = 2'b10
  } zqcal_state_t;
endpackage : zqcal_pkg

// ===== verification/test_zq_calibration_sequencing.sv
// self-checking bench: controller and device ends face each other on the link
`include "zqcal_defines.svh"
module test_zq_calibration_sequencing;
  timeunit 1ns;
  timeprecision 1ps;
  import zqcal_pkg::*;
  logic       ref_clk_in    = 1'b0;
  logic       rstn_in       = 1'b0;
  logic       zq_req_in     = 1'b0;
  logic       zq_long_in    = 1'b0;
  logic       sr_exit_in    = 1'b0;
  logic       share_busy_in = 1'b0;
  logic [7:0] cal_target_in = 8'h80;
  logic [7:0] drv_code_out, odt_code_out;
  logic       share_busy_out, ready_out, busy_out, done_out;
  logic       cal_active_out, cal_current_out, viol_out, viol_e;
  int         mismatches    = 0;
  int         checks_done   = 0;
  int         cyc           = 0;
  int         zq_at;
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc++;
  zqcal_if zqcal_if_i ();
  zqcal_if zqcal_if_e_i ();
  zqcal_ctl zqcal_ctl_i (.ref_clk_in, .rstn_in, .link(zqcal_if_i.ctl), .zq_req_in,
    .zq_long_in, .sr_exit_in, .share_busy_in, .share_busy_out, .ready_out, .busy_out,
    .done_out);
  zqcal_dev zqcal_dev_i (.ref_clk_in, .rstn_in, .link(zqcal_if_i.dev), .cal_target_in,
    .drv_code_out, .odt_code_out, .cal_active_out, .cal_current_out, .viol_out);
  // second device faces the bench, which breaks the quiet rule on purpose
  zqcal_dev zqcal_dev_e_i (.ref_clk_in, .rstn_in, .link(zqcal_if_e_i.dev), .cal_target_in,
    .drv_code_out(), .odt_code_out(), .cal_active_out(), .cal_current_out(),
    .viol_out(viol_e));
  zqcal_props zqcal_props_i (.ref_clk_in, .rstn_in, .cmd(zqcal_if_i.cmd),
    .addr(zqcal_if_i.addr), .cke(zqcal_if_i.cke), .odt(zqcal_if_i.odt),
    .ctl_dq_oe(zqcal_if_i.ctl_dq_oe), .dev_dq_oe(zqcal_if_i.dev_dq_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic give_up(input string what);
    $display("[FAIL] %s expected handshake seen timeout", what);
    mismatches++;
    complete_run();
  endtask
  task automatic run_cal(input logic lng, input int len, input logic [7:0] tgt);
    int n;
    logic [7:0] old;
    logic dn;
    old = drv_code_out;
    dn = 1'b0;
    for (n = 0; ready_out !== 1'b1; n++) begin
      if (n > 900) give_up("ready");
      @(negedge ref_clk_in);
    end
    cal_target_in = tgt;
    zq_long_in = lng;
    zq_req_in = 1'b1;
    @(negedge ref_clk_in);
    zq_req_in = 1'b0;
    for (n = 0; zqcal_if_i.cmd !== ZQCAL_CMD_ZQ; n++) begin
      if (n > 300) give_up("command");
      @(negedge ref_clk_in);
    end
    zq_at = cyc;
    chk("long select", zqcal_if_i.addr[`ZQCAL_LONG_BIT], lng);
    chk("codes before", drv_code_out, old);
    @(negedge ref_clk_in);
    chk("busy", {busy_out, share_busy_out}, 2'b11);
    // done stands for one cycle inside the last window cycle, so watch it here
    for (n = 0; cal_active_out === 1'b1; n++) begin
      if (n > 600) give_up("window");
      dn = dn | (done_out === 1'b1);
      @(negedge ref_clk_in);
    end
    chk("window", n, len);
    chk("codes", {drv_code_out, odt_code_out, cal_current_out, viol_out},
        {tgt, tgt, 2'b00});
    chk("done pulse", {dn, done_out}, 2'b10);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fault();
    zqcal_if_e_i.cmd = ZQCAL_CMD_ZQ;
    @(negedge ref_clk_in);
    zqcal_if_e_i.cmd = ZQCAL_CMD_NOP;
    repeat (3) @(negedge ref_clk_in);
    chk("quiet flag", viol_e, 1'b0);
    zqcal_if_e_i.cmd = ZQCAL_CMD_PRE;
    @(negedge ref_clk_in);
    zqcal_if_e_i.cmd = ZQCAL_CMD_NOP;
    @(negedge ref_clk_in);
    chk("activity flag", viol_e, 1'b1);
    $display("test fault finished");
  endtask
  // short first: it must not use up the longer first window
  // targets stay within one step per window cycle of the previous code
  task automatic t_first();
    run_cal(1'b0, `ZQCAL_TZQCS_CYC, 8'h61);
    run_cal(1'b1, `ZQCAL_TZQINIT_CYC, 8'h5A);
    run_cal(1'b1, `ZQCAL_TZQOPER_CYC, 8'hC3);
    $display("test first finished");
  endtask
  task automatic t_self_refresh();
    int s;
    sr_exit_in = 1'b1;
    @(negedge ref_clk_in);
    sr_exit_in = 1'b0;
    s = cyc;
    run_cal(1'b0, `ZQCAL_TZQCS_CYC, 8'h96);
    chk("exit spacing", zq_at - s >= `ZQCAL_TXS_CYC, 1'b1);
    $display("test self refresh finished");
  endtask
  task automatic t_share();
    int s;
    share_busy_in = 1'b1;
    s = cyc;
    fork
      begin
        repeat (40) @(negedge ref_clk_in);
        share_busy_in = 1'b0;
      end
    join_none
    run_cal(1'b1, `ZQCAL_TZQOPER_CYC, 8'h4B);
    chk("shared wait", zq_at - s > 40, 1'b1);
    $display("test share finished");
  endtask
  // a reset between runs, after the last window has closed, must re-arm the longer first window
  task automatic t_reset();
    rstn_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("reset codes", {drv_code_out, zqcal_if_i.cke}, {`ZQCAL_CAL_RESET, 1'b0});
    rstn_in = 1'b1;
    run_cal(1'b1, `ZQCAL_TZQINIT_CYC, 8'h70);
    $display("test reset finished");
  endtask
  initial begin
    zqcal_if_e_i.cmd = ZQCAL_CMD_NOP;
    zqcal_if_e_i.addr = '0;
    zqcal_if_e_i.cke = 1'b1;
    zqcal_if_e_i.odt = 1'b0;
    zqcal_if_e_i.ctl_dq_oe = 1'b0;
    repeat (16) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    t_fault();
    t_first();
    t_self_refresh();
    t_share();
    t_reset();
    complete_run();
  end
endmodule // test_zq_calibration_sequencing

// ===== verification/zqcal_props.sv
// concurrent checks on the link between controller and device ends
`include "zqcal_defines.svh"
module zqcal_props
  import zqcal_pkg::*;
(
  input wire logic                     ref_clk_in,
  input wire logic                     rstn_in,
  input wire zqcal_cmd_t               cmd,
  input wire logic [`ZQCAL_ADDR_W-1:0] addr,
  input wire logic                     cke,
  input wire logic                     odt,
  input wire logic                     ctl_dq_oe,
  input wire logic                     dev_dq_oe
);
  logic       first_q;
  logic [9:0] win_q;
  logic [1:0] age_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////
  // a short one leaves the first-long flag alone, so the model tracks it apart
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) first_q <= 1'b1;
    else if (cmd == ZQCAL_CMD_ZQ && addr[`ZQCAL_LONG_BIT]) first_q <= 1'b0;
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) win_q <= '0;
    else if (cmd == ZQCAL_CMD_ZQ && win_q == '0)
      win_q <= !addr[`ZQCAL_LONG_BIT] ? 10'(`ZQCAL_TZQCS_CYC) :
               first_q ? 10'(`ZQCAL_TZQINIT_CYC) : 10'(`ZQCAL_TZQOPER_CYC);
    else if (win_q != '0) win_q <= win_q - 10'h001;
  end
  // age since the last precharge; a calibration uses it up
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) age_q <= 2'h0;
    else if (cmd == ZQCAL_CMD_PRE) age_q <= 2'h1;
    else if (cmd == ZQCAL_CMD_ZQ) age_q <= 2'h0;
    else if (age_q != 2'h0 && age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_pre_gap;
    cmd == ZQCAL_CMD_PRE |=> (cmd != ZQCAL_CMD_ZQ) [*2];
  endproperty
  a_pre_gap: assert property (p_pre_gap) else $error("calibration too soon");
  property p_pre_first;
    cmd == ZQCAL_CMD_ZQ |-> age_q == 2'h3;
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("no precharge first");
  property p_quiet;
    win_q != '0 |-> cmd inside {ZQCAL_CMD_NOP, ZQCAL_CMD_DES};
  endproperty
  a_quiet: assert property (p_quiet) else $error("command in window");
  property p_cke;
    win_q != '0 |-> cke;
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable low in window");
  property p_odt;
    win_q != '0 |-> !odt;
  endproperty
  a_odt: assert property (p_odt) else $error("termination on in window");
  property p_dq;
    win_q != '0 |-> !ctl_dq_oe && !dev_dq_oe;
  endproperty
  a_dq: assert property (p_dq) else $error("data bus driven in window");
  property p_zq_cke;
    cmd == ZQCAL_CMD_ZQ |-> cke && $past(cke);
  endproperty
  a_zq_cke: assert property (p_zq_cke) else $error("clock enable low at command");
  property p_zq_odt;
    cmd == ZQCAL_CMD_ZQ |-> !odt && !ctl_dq_oe;
  endproperty
  a_zq_odt: assert property (p_zq_odt) else $error("bus busy at command");
endmodule // zqcal_props
